// ==== logic/bbx_exec.sv ====
/*
  Execution sequencer for branches on overflow clear and on interrupt flag set or clear, I/O bit set
  and clear, shifts and rotates, T flag transfers, flag set and clear, and data
  and program memory transfers. Holds program counter, status flags and the
  three pointer pairs.
  Assumes a decoder on the same clock, a register file that takes one write
  per cycle, and data, I/O and program memories with combinational read data.
*/
`default_nettype none


module bbx_exec
  import bbx_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Decoded operation
  input wire logic opStart,
  input wire bbx_op_t opKind,
  input wire logic [4:0] opRegIdx,
  input wire logic [7:0] opRegData,
  input wire logic [2:0] opBitSel,
  input wire logic [2:0] opFlagSel,
  input wire logic [6:0] opOffset,
  input wire logic [1:0] opPtrSel,
  input wire logic [5:0] opDisp,
  input wire logic [15:0] opDirectAddr,
  input wire logic [5:0] opIoAddr,
  // Handshake
  output logic opReady,
  output logic opDone,
  // Register file write
  output logic regWe,
  output logic [4:0] regWrIdx,
  output logic [7:0] regWrData,
  // Data memory
  output logic [15:0] dmAddr,
  output logic dmRe,
  output logic dmWe,
  output logic [7:0] dmWrData,
  input wire logic [7:0] dmRdData,
  // I/O registers
  output logic [5:0] ioAddr,
  output logic ioRe,
  output logic ioWe,
  output logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  // Program memory, word addressed
  output logic [14:0] pmAddr,
  output logic pmRe,
  input wire logic [15:0] pmRdData,
  // Core state loads from the rest of the core
  input wire logic pcLoad,
  input wire logic [15:0] pcLoadValue,
  input wire logic flagsLoad,
  input wire logic [7:0] flagsLoadValue,
  input wire logic ptrLoad,
  input wire logic [1:0] ptrLoadSel,
  input wire logic [15:0] ptrLoadValue,
  // Core state
  output logic [15:0] pc,
  output logic [7:0] statusFlags,
  output logic [15:0] ptrX,
  output logic [15:0] ptrY,
  output logic [15:0] ptrZ
);

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_EXEC2,
    SQ_EXEC3
  } bbx_state_t;

  bbx_state_t state_r, state_nxt;
  bbx_op_t kind_r, kind_nxt;
  logic [2:0] bitSel_r, bitSel_nxt;
  logic byteSel_r, byteSel_nxt;
  logic opDone_r, opDone_nxt;
  logic regWe_r, regWe_nxt;
  logic [4:0] regWrIdx_r, regWrIdx_nxt;
  logic [7:0] regWrData_r, regWrData_nxt;
  logic [15:0] dmAddr_r, dmAddr_nxt;
  logic dmRe_r, dmRe_nxt;
  logic dmWe_r, dmWe_nxt;
  logic [7:0] dmWrData_r, dmWrData_nxt;
  logic [5:0] ioAddr_r, ioAddr_nxt;
  logic ioRe_r, ioRe_nxt;
  logic ioWe_r, ioWe_nxt;
  logic [7:0] ioWrData_r, ioWrData_nxt;
  logic [14:0] pmAddr_r, pmAddr_nxt;
  logic pmRe_r, pmRe_nxt;

  logic [15:0] pc_r, pc_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [15:0] ptrX_r, ptrX_nxt;
  logic [15:0] ptrY_r, ptrY_nxt;
  logic [15:0] ptrZ_r, ptrZ_nxt;

  logic accept;
  logic branchTaken;
  logic [15:0] ptrCur;
  logic [15:0] ptrUpd;
  logic ptrWrite;
  logic [15:0] memAddr;
  logic [15:0] offsetExt;

  bbx_alu_if alu ();

  bbx_shift_unit u_shift (
    .alu(alu)
  );

  assign opReady = (state_r == SQ_IDLE);
  assign accept = opStart && opReady;

  // During the second cycle of an I/O bit op the unit works on the read-back value
  always_comb begin
    alu.operand = (state_r == SQ_EXEC2) ? ioRdData : opRegData;
    alu.bitSel = (state_r == SQ_EXEC2) ? bitSel_r : opBitSel;
    alu.carryIn = flags_r[FLG_C];
    alu.tIn = flags_r[FLG_T];
    case (opKind)
      OP_SHIFT_RIGHT_LOGICAL: alu.shiftKind = SHK_RIGHT_LOGICAL;
      OP_ROTATE_LEFT_CARRY: alu.shiftKind = SHK_LEFT_CARRY;
      OP_ROTATE_RIGHT_CARRY: alu.shiftKind = SHK_RIGHT_CARRY;
      default: alu.shiftKind = SHK_LEFT_LOGICAL;
    endcase
  end

  // Branch condition and address generation
  always_comb begin
    offsetExt = {{9{opOffset[6]}}, opOffset};
    case (opKind)
      OP_BRANCH_ON_NO_OVERFLOW: branchTaken = !flags_r[FLG_V];
      OP_BRANCH_ON_IRQ_ENABLED: branchTaken = flags_r[FLG_I];
      OP_BRANCH_ON_IRQ_DISABLED: branchTaken = !flags_r[FLG_I];
      default: branchTaken = 1'b0;
    endcase
    case (opPtrSel)
      PTR_X: ptrCur = ptrX_r;
      PTR_Y: ptrCur = ptrY_r;
      default: ptrCur = ptrZ_r;
    endcase
    ptrUpd = ptrCur;
    ptrWrite = 1'b0;
    memAddr = ptrCur;
    case (opKind)
      OP_INDIRECT_LOAD_INC, OP_INDIRECT_STORE_INC: begin
        ptrUpd = ptrCur + ONE16;
        ptrWrite = 1'b1;
      end
      OP_INDIRECT_LOAD_DEC, OP_INDIRECT_STORE_DEC: begin
        ptrUpd = ptrCur - ONE16;
        ptrWrite = 1'b1;
        memAddr = ptrCur - ONE16;
      end
      OP_DISPLACED_LOAD, OP_DISPLACED_STORE: begin
        // X has no displaced form, so it falls back to plain indirect
        if (opPtrSel != PTR_X) begin
          memAddr = ptrCur + {10'h000, opDisp};
        end
      end
      OP_DIRECT_STORE: memAddr = opDirectAddr;
      default: memAddr = ptrCur;
    endcase
  end

  // Architectural state; an operation overrides a same-cycle external load
  always_comb begin
    pc_nxt = pcLoad ? pcLoadValue : pc_r;
    flags_nxt = flagsLoad ? flagsLoadValue : flags_r;
    ptrX_nxt = ptrX_r;
    ptrY_nxt = ptrY_r;
    ptrZ_nxt = ptrZ_r;
    if (ptrLoad) begin
      case (ptrLoadSel)
        PTR_X: ptrX_nxt = ptrLoadValue;
        PTR_Y: ptrY_nxt = ptrLoadValue;
        default: ptrZ_nxt = ptrLoadValue;
      endcase
    end
    if (accept) begin
      pc_nxt = pc_r + ONE16;
      if (branchTaken) begin
        pc_nxt = pc_r + offsetExt + ONE16;
      end
      case (opKind)
        OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL: begin
          flags_nxt[FLG_C] = alu.shiftC;
          flags_nxt[FLG_Z] = alu.shiftZ;
          flags_nxt[FLG_N] = alu.shiftN;
          flags_nxt[FLG_V] = alu.shiftV;
        end
        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: begin
          flags_nxt[FLG_C] = alu.shiftC;
          flags_nxt[FLG_Z] = alu.shiftZ;
          flags_nxt[FLG_N] = alu.shiftN;
          flags_nxt[FLG_V] = alu.shiftV;
        end
        OP_BIT_TO_TFLAG: flags_nxt[FLG_T] = alu.bitPicked;
        OP_FLAG_SET: flags_nxt[opFlagSel] = 1'b1;
        OP_FLAG_CLEAR: flags_nxt[opFlagSel] = 1'b0;
        OP_PROGRAM_MEMORY_LOAD_INC: ptrZ_nxt = ptrZ_r + ONE16;
        default: begin
          if (ptrWrite) begin
            case (opPtrSel)
              PTR_X: ptrX_nxt = ptrUpd;
              PTR_Y: ptrY_nxt = ptrUpd;
              default: ptrZ_nxt = ptrUpd;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pc_r <= PC_RESET;
      flags_r <= FLAGS_RESET;
      ptrX_r <= PTR_RESET;
      ptrY_r <= PTR_RESET;
      ptrZ_r <= PTR_RESET;
    end else begin
      pc_r <= pc_nxt;
      flags_r <= flags_nxt;
      ptrX_r <= ptrX_nxt;
      ptrY_r <= ptrY_nxt;
      ptrZ_r <= ptrZ_nxt;
    end
  end

  // Sequencer and bus outputs
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    bitSel_nxt = bitSel_r;
    byteSel_nxt = byteSel_r;
    opDone_nxt = 1'b0;
    regWe_nxt = 1'b0;
    regWrIdx_nxt = regWrIdx_r;
    regWrData_nxt = regWrData_r;
    dmAddr_nxt = dmAddr_r;
    dmRe_nxt = 1'b0;
    dmWe_nxt = 1'b0;
    dmWrData_nxt = dmWrData_r;
    ioAddr_nxt = ioAddr_r;
    ioRe_nxt = 1'b0;
    ioWe_nxt = 1'b0;
    ioWrData_nxt = ioWrData_r;
    pmAddr_nxt = pmAddr_r;
    pmRe_nxt = 1'b0;
    case (state_r)
      SQ_IDLE: begin
        if (accept) begin
          kind_nxt = opKind;
          bitSel_nxt = opBitSel;
          regWrIdx_nxt = opRegIdx;
          case (opKind)
            OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
            OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: begin
              regWe_nxt = 1'b1;
              regWrData_nxt = alu.shiftResult;
              opDone_nxt = 1'b1;
            end
            OP_TFLAG_TO_BIT: begin
              regWe_nxt = 1'b1;
              regWrData_nxt = alu.bitInserted;
              opDone_nxt = 1'b1;
            end
            OP_BRANCH_ON_NO_OVERFLOW, OP_BRANCH_ON_IRQ_ENABLED,
            OP_BRANCH_ON_IRQ_DISABLED: begin
              if (branchTaken) begin
                state_nxt = SQ_EXEC2;
              end else begin
                opDone_nxt = 1'b1;
              end
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
              ioAddr_nxt = opIoAddr;
              ioRe_nxt = 1'b1;
              state_nxt = SQ_EXEC2;
            end
            OP_INDIRECT_LOAD, OP_INDIRECT_LOAD_INC, OP_INDIRECT_LOAD_DEC,
            OP_DISPLACED_LOAD: begin
              dmAddr_nxt = memAddr;
              dmRe_nxt = 1'b1;
              state_nxt = SQ_EXEC2;
            end
            OP_INDIRECT_STORE, OP_INDIRECT_STORE_INC, OP_INDIRECT_STORE_DEC,
            OP_DISPLACED_STORE, OP_DIRECT_STORE: begin
              dmAddr_nxt = memAddr;
              dmWe_nxt = 1'b1;
              dmWrData_nxt = opRegData;
              state_nxt = SQ_EXEC2;
            end
            OP_PROGRAM_MEMORY_LOAD_R0, OP_PROGRAM_MEMORY_LOAD,
            OP_PROGRAM_MEMORY_LOAD_INC: begin
              pmAddr_nxt = ptrZ_r[15:1];
              byteSel_nxt = ptrZ_r[0];
              pmRe_nxt = 1'b1;
              if (opKind == OP_PROGRAM_MEMORY_LOAD_R0) begin
                regWrIdx_nxt = REG_R0;
              end
              state_nxt = SQ_EXEC2;
            end
            default: opDone_nxt = 1'b1;
          endcase
        end
      end
      SQ_EXEC2: begin
        state_nxt = SQ_IDLE;
        opDone_nxt = 1'b1;
        case (kind_r)
          OP_IO_BIT_SET: begin
            ioWe_nxt = 1'b1;
            ioWrData_nxt = alu.bitSetResult;
          end
          OP_IO_BIT_CLEAR: begin
            ioWe_nxt = 1'b1;
            ioWrData_nxt = alu.bitClearResult;
          end
          OP_INDIRECT_LOAD, OP_INDIRECT_LOAD_INC, OP_INDIRECT_LOAD_DEC,
          OP_DISPLACED_LOAD: begin
            regWe_nxt = 1'b1;
            regWrData_nxt = dmRdData;
          end
          OP_PROGRAM_MEMORY_LOAD_R0, OP_PROGRAM_MEMORY_LOAD,
          OP_PROGRAM_MEMORY_LOAD_INC: begin
            // Address held a second cycle so slow program memory can settle
            pmRe_nxt = 1'b1;
            opDone_nxt = 1'b0;
            state_nxt = SQ_EXEC3;
          end
          default: begin
          end
        endcase
      end
      SQ_EXEC3: begin
        regWe_nxt = 1'b1;
        regWrData_nxt = byteSel_r ? pmRdData[15:8] : pmRdData[7:0];
        opDone_nxt = 1'b1;
        state_nxt = SQ_IDLE;
      end
      default: state_nxt = SQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= SQ_IDLE;
      kind_r <= OP_NOP;
      bitSel_r <= 3'h0;
      byteSel_r <= 1'b0;
      opDone_r <= 1'b0;
      regWe_r <= 1'b0;
      regWrIdx_r <= 5'h00;
      regWrData_r <= 8'h00;
      dmAddr_r <= 16'h0000;
      dmRe_r <= 1'b0;
      dmWe_r <= 1'b0;
      dmWrData_r <= 8'h00;
      ioAddr_r <= 6'h00;
      ioRe_r <= 1'b0;
      ioWe_r <= 1'b0;
      ioWrData_r <= 8'h00;
      pmAddr_r <= 15'h0000;
      pmRe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      bitSel_r <= bitSel_nxt;
      byteSel_r <= byteSel_nxt;
      opDone_r <= opDone_nxt;
      regWe_r <= regWe_nxt;
      regWrIdx_r <= regWrIdx_nxt;
      regWrData_r <= regWrData_nxt;
      dmAddr_r <= dmAddr_nxt;
      dmRe_r <= dmRe_nxt;
      dmWe_r <= dmWe_nxt;
      dmWrData_r <= dmWrData_nxt;
      ioAddr_r <= ioAddr_nxt;
      ioRe_r <= ioRe_nxt;
      ioWe_r <= ioWe_nxt;
      ioWrData_r <= ioWrData_nxt;
      pmAddr_r <= pmAddr_nxt;
      pmRe_r <= pmRe_nxt;
    end
  end

  assign opDone = opDone_r;
  assign regWe = regWe_r;
  assign regWrIdx = regWrIdx_r;
  assign regWrData = regWrData_r;
  assign dmAddr = dmAddr_r;
  assign dmRe = dmRe_r;
  assign dmWe = dmWe_r;
  assign dmWrData = dmWrData_r;
  assign ioAddr = ioAddr_r;
  assign ioRe = ioRe_r;
  assign ioWe = ioWe_r;
  assign ioWrData = ioWrData_r;
  assign pmAddr = pmAddr_r;
  assign pmRe = pmRe_r;
  assign pc = pc_r;
  assign statusFlags = flags_r;
  assign ptrX = ptrX_r;
  assign ptrY = ptrY_r;
  assign ptrZ = ptrZ_r;

endmodule : bbx_exec

`default_nettype wire

// ==== logic/bbx_pkg.sv ====
/*
  Shared constants and types of the bit, branch and transfer execution block.
  Assumes a decoder outside that presents one decoded operation at a time.
*/
`default_nettype none

package bbx_pkg;

  // Decoded operation kinds
  typedef enum logic [4:0] {
    OP_NOP,
    OP_BRANCH_ON_NO_OVERFLOW,
    OP_BRANCH_ON_IRQ_ENABLED,
    OP_BRANCH_ON_IRQ_DISABLED,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_SHIFT_LEFT_LOGICAL,
    OP_SHIFT_RIGHT_LOGICAL,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_BIT_TO_TFLAG,
    OP_TFLAG_TO_BIT,
    OP_FLAG_SET,
    OP_FLAG_CLEAR,
    OP_INDIRECT_LOAD,
    OP_INDIRECT_LOAD_INC,
    OP_INDIRECT_LOAD_DEC,
    OP_DISPLACED_LOAD,
    OP_INDIRECT_STORE,
    OP_INDIRECT_STORE_INC,
    OP_INDIRECT_STORE_DEC,
    OP_DISPLACED_STORE,
    OP_DIRECT_STORE,
    OP_PROGRAM_MEMORY_LOAD_R0,
    OP_PROGRAM_MEMORY_LOAD,
    OP_PROGRAM_MEMORY_LOAD_INC
  } bbx_op_t;

  // Shift unit modes
  typedef enum logic [1:0] {
    SHK_LEFT_LOGICAL,
    SHK_RIGHT_LOGICAL,
    SHK_LEFT_CARRY,
    SHK_RIGHT_CARRY
  } bbx_shift_t;

  // Field positions in the status flags register
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // Pointer pair selects
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;

  // Reset values and fixed constants
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [4:0] REG_R0 = 5'h00;
  localparam logic [7:0] BIT_ONE = 8'h01;

endpackage : bbx_pkg

`default_nettype wire

// ==== logic/bbx_alu_if.sv ====
/*
  Carrier between the sequencer and its shift and bit unit.
  Assumes both ends sit on the same clock; the unit is purely combinational.
*/
`default_nettype none

interface bbx_alu_if;
  import bbx_pkg::*;

  logic [7:0] operand;
  bbx_shift_t shiftKind;
  logic carryIn;
  logic [2:0] bitSel;
  logic tIn;
  logic [7:0] shiftResult;
  logic shiftC;
  logic shiftZ;
  logic shiftN;
  logic shiftV;
  logic bitPicked;
  logic [7:0] bitInserted;
  logic [7:0] bitSetResult;
  logic [7:0] bitClearResult;

  modport unit (
    input operand, shiftKind, carryIn, bitSel, tIn,
    output shiftResult, shiftC, shiftZ, shiftN, shiftV,
    output bitPicked, bitInserted, bitSetResult, bitClearResult
  );

  modport user (
    output operand, shiftKind, carryIn, bitSel, tIn,
    input shiftResult, shiftC, shiftZ, shiftN, shiftV,
    input bitPicked, bitInserted, bitSetResult, bitClearResult
  );

endinterface : bbx_alu_if

`default_nettype wire

// ==== logic/bbx_shift_unit.sv ====
/*
  Shift, rotate and single-bit unit.
  Assumes the user side holds operand and selects stable for the cycle.
*/
`default_nettype none

module bbx_shift_unit
  import bbx_pkg::*;
(
  // Operands and results
  bbx_alu_if.unit alu
);

  logic [7:0] mask;

  always_comb begin
    alu.shiftResult = 8'h00;
    alu.shiftC = 1'b0;
    case (alu.shiftKind)
      SHK_LEFT_LOGICAL: begin
        alu.shiftResult = {alu.operand[6:0], 1'b0};
        alu.shiftC = alu.operand[7];
      end
      SHK_RIGHT_LOGICAL: begin
        alu.shiftResult = {1'b0, alu.operand[7:1]};
        alu.shiftC = alu.operand[0];
      end
      SHK_LEFT_CARRY: begin
        alu.shiftResult = {alu.operand[6:0], alu.carryIn};
        alu.shiftC = alu.operand[7];
      end
      SHK_RIGHT_CARRY: begin
        alu.shiftResult = {alu.carryIn, alu.operand[7:1]};
        alu.shiftC = alu.operand[0];
      end
      default: begin
        alu.shiftResult = alu.operand;
        alu.shiftC = alu.carryIn;
      end
    endcase
    alu.shiftN = alu.shiftResult[7];
    alu.shiftZ = (alu.shiftResult == 8'h00);
    alu.shiftV = alu.shiftN ^ alu.shiftC;
  end

  always_comb begin
    mask = BIT_ONE << alu.bitSel;
    alu.bitPicked = alu.operand[alu.bitSel];
    alu.bitInserted = alu.tIn ? (alu.operand | mask) : (alu.operand & ~mask);
    alu.bitSetResult = alu.operand | mask;
    alu.bitClearResult = alu.operand & ~mask;
  end

endmodule : bbx_shift_unit

`default_nettype wire

// ==== test/bbx_exec_properties.sv ====
/*
  Port checker of the execution sequencer, bound to its top module.
  Assumes one clock domain; memory read data is combinational.
*/
`default_nettype none
module bbx_exec_props
  import bbx_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Operation
  input wire logic opStart,
  input wire bbx_op_t opKind,
  input wire logic [7:0] opRegData,
  input wire logic [2:0] opBitSel,
  input wire logic [2:0] opFlagSel,
  input wire logic [6:0] opOffset,
  input wire logic [1:0] opPtrSel,
  input wire logic [5:0] opIoAddr,
  input wire logic opReady,
  input wire logic opDone,
  // Results and memories
  input wire logic regWe,
  input wire logic [7:0] regWrData,
  input wire logic [15:0] dmAddr,
  input wire logic dmRe,
  input wire logic [7:0] dmRdData,
  input wire logic [5:0] ioAddr,
  input wire logic ioRe,
  input wire logic ioWe,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic pmRe,
  // Core state
  input wire logic [15:0] pc,
  input wire logic [7:0] statusFlags,
  input wire logic [15:0] ptrX
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic go;
  assign go = opStart && opReady;
  property p_shl;
    go && opKind == OP_SHIFT_LEFT_LOGICAL |=> opDone && regWe &&
      regWrData == {$past(opRegData[6:0]), 1'b0} && statusFlags[FLG_C] == $past(opRegData[7]);
  endproperty
  a_shl: assert property (p_shl) else $error("left shift wrong");
  property p_shr;
    go && opKind == OP_SHIFT_RIGHT_LOGICAL |=> opDone &&
      regWrData == {1'b0, $past(opRegData[7:1])} && statusFlags[FLG_C] == $past(opRegData[0]);
  endproperty
  a_shr: assert property (p_shr) else $error("right shift wrong");
  property p_rol;
    go && opKind == OP_ROTATE_LEFT_CARRY |=> opDone &&
      regWrData == {$past(opRegData[6:0]), $past(statusFlags[FLG_C])};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");
  property p_vc_taken;
    go && opKind == OP_BRANCH_ON_NO_OVERFLOW && !statusFlags[FLG_V] |=> !opDone &&
      pc == $past(pc) + {{9{$past(opOffset[6])}}, $past(opOffset)} + 16'h0001 ##1 opDone;
  endproperty
  a_vc_taken: assert property (p_vc_taken) else $error("taken branch wrong");
  property p_untaken;
    go && opKind == OP_BRANCH_ON_NO_OVERFLOW && statusFlags[FLG_V] |=>
      opDone && pc == $past(pc) + 16'h0001;
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken branch wrong");
  property p_irq;
    go && opKind inside {OP_BRANCH_ON_IRQ_ENABLED, OP_BRANCH_ON_IRQ_DISABLED} &&
      ((opKind == OP_BRANCH_ON_IRQ_ENABLED) == statusFlags[FLG_I]) |=> !opDone ##1 opDone;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt branch timing wrong");
  property p_io;
    go && opKind == OP_IO_BIT_SET |=> ioRe && ioAddr == $past(opIoAddr) ##1 ioWe && opDone &&
      ioWrData == ($past(ioRdData) | (8'h01 << $past(opBitSel, 2)));
  endproperty
  a_io: assert property (p_io) else $error("io bit set wrong");
  property p_ldx;
    go && opKind == OP_INDIRECT_LOAD_INC && opPtrSel == PTR_X |=> dmRe &&
      dmAddr == $past(ptrX) && ptrX == $past(ptrX) + 16'h0001 ##1
      regWe && opDone && regWrData == $past(dmRdData);
  endproperty
  a_ldx: assert property (p_ldx) else $error("post-increment load wrong");
  property p_pm;
    go && opKind inside {OP_PROGRAM_MEMORY_LOAD_R0, OP_PROGRAM_MEMORY_LOAD,
      OP_PROGRAM_MEMORY_LOAD_INC} |=> pmRe [*2] ##1 regWe && opDone && !pmRe;
  endproperty
  a_pm: assert property (p_pm) else $error("program load timing wrong");
  property p_flag;
    go && opKind == OP_FLAG_SET |=> opDone &&
      statusFlags == ($past(statusFlags) | (8'h01 << $past(opFlagSel)));
  endproperty
  a_flag: assert property (p_flag) else $error("flag set wrong");
endmodule : bbx_exec_props

bind bbx_exec bbx_exec_props u_props (.sys_clk, .reset, .opStart, .opKind, .opRegData,
  .opBitSel, .opFlagSel, .opOffset, .opPtrSel, .opIoAddr, .opReady, .opDone, .regWe,
  .regWrData, .dmAddr, .dmRe, .dmRdData, .ioAddr, .ioRe, .ioWe, .ioWrData, .ioRdData, .pmRe,
  .pc, .statusFlags, .ptrX);
`default_nettype wire

// ==== test/bbx_exec_bench.sv ====
/*
  Self-checking bench of the execution sequencer.
  Assumes memories whose read data is a fixed function of the address.
*/
`default_nettype none
module bbx_exec_bench;
  import bbx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, reset = 1'b1, opStart = 1'b0, pcLoad = 1'b0, flagsLoad = 1'b0;
  logic ptrLoad = 1'b0, opReady, opDone, regWe, dmRe, dmWe, ioRe, ioWe, pmRe, c;
  bbx_op_t opKind = OP_NOP, k;
  logic [4:0] opRegIdx = 5'h00, regWrIdx;
  logic [7:0] opRegData = 8'h00, flagsLoadValue = 8'h00, fl = 8'h00, r;
  logic [7:0] regWrData, dmWrData, dmRdData, ioWrData, ioRdData, statusFlags;
  logic [2:0] opBitSel = 3'h0, opFlagSel = 3'h0;
  logic [6:0] opOffset = 7'h00;
  logic [1:0] opPtrSel = PTR_X, ptrLoadSel = PTR_X;
  logic [5:0] opDisp = 6'h00, opIoAddr = 6'h00, ioAddr;
  logic [15:0] opDirectAddr = 16'h0000, pcLoadValue = 16'h0000, ptrLoadValue = 16'h0000;
  logic [15:0] dmAddr, pmRdData, pc, ptrX, ptrY, ptrZ;
  logic [14:0] pmAddr;
  int n_errors = 0, num_checks = 0, cyc = 0, dmWrites = 0;

  bbx_exec DUT (.sys_clk, .reset, .opStart, .opKind, .opRegIdx, .opRegData, .opBitSel,
    .opFlagSel, .opOffset, .opPtrSel, .opDisp, .opDirectAddr, .opIoAddr, .opReady, .opDone,
    .regWe, .regWrIdx, .regWrData, .dmAddr, .dmRe, .dmWe, .dmWrData, .dmRdData, .ioAddr,
    .ioRe, .ioWe, .ioWrData, .ioRdData, .pmAddr, .pmRe, .pmRdData, .pcLoad, .pcLoadValue,
    .flagsLoad, .flagsLoadValue, .ptrLoad, .ptrLoadSel, .ptrLoadValue, .pc, .statusFlags,
    .ptrX, .ptrY, .ptrZ);

  // Address-derived read data keeps expectations free of a memory array
  assign dmRdData = dmAddr[7:0] ^ 8'h5A;
  assign ioRdData = {2'h0, ioAddr} ^ 8'hC3;
  assign pmRdData = {pmAddr[7:0], ~pmAddr[7:0]};
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    // Write strobe lasts one cycle, so stores are judged by this count
    if (dmWe === 1'b1) begin
      dmWrites <= dmWrites + 1;
    end
    if (cyc == 2000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Entered 2 ns after an edge with the sequencer idle; counts cycles to completion
  task automatic run(input bbx_op_t kind, input int want);
    int n;
    n = 1;
    opKind = kind;
    opStart = 1'b1;
    @(posedge sys_clk);
    #2 opStart = 1'b0;
    while (opDone !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #2 n++;
    end
    chk("cycles", 16'(n), 16'(want));
  endtask : run

  task automatic setPtr(input logic [1:0] s, input logic [15:0] v);
    ptrLoad = 1'b1;
    ptrLoadSel = s;
    ptrLoadValue = v;
    @(posedge sys_clk);
    #2 ptrLoad = 1'b0;
  endtask : setPtr

  task automatic br(input bbx_op_t kind, input logic [6:0] off, input logic tk);
    logic [15:0] p;
    p = pc;
    fl = statusFlags;
    opOffset = off;
    run(kind, tk ? 2 : 1);
    chk("pc", pc, p + (tk ? {{9{off[6]}}, off} : 16'h0000) + 16'h0001);
    chk("bflags", 16'(statusFlags), 16'(fl));
  endtask : br

  task automatic memLoad(input bbx_op_t kind, input logic [1:0] s, input logic [15:0] a,
      input logic [15:0] p);
    opPtrSel = s;
    run(kind, 2);
    chk("ldaddr", dmAddr, a);
    chk("lddata", 16'(regWrData), 16'(a[7:0] ^ 8'h5A));
    chk("ldptr", s == PTR_X ? ptrX : s == PTR_Y ? ptrY : ptrZ, p);
  endtask : memLoad

  task automatic memStore(input bbx_op_t kind, input logic [15:0] a, input logic [15:0] y);
    int w;
    w = dmWrites;
    opRegData = a[15:8] ^ a[7:0];
    run(kind, 2);
    chk("staddr", dmAddr, a);
    chk("stdata", 16'(dmWrData), 16'(a[15:8] ^ a[7:0]));
    chk("stptr", ptrY, y);
    chk("stwe", 16'(dmWrites - w), 16'h0001);
  endtask : memStore

  initial begin
    repeat (10) @(posedge sys_clk);
    #2 reset = 1'b0;
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 8; i++) begin
        opFlagSel = i[2:0];
        fl[i] = (j == 0);
        run(j == 0 ? OP_FLAG_SET : OP_FLAG_CLEAR, 1);
        chk("flags", 16'(statusFlags), 16'(fl));
      end
    end
    br(OP_BRANCH_ON_NO_OVERFLOW, 7'h7E, 1'b1);
    opFlagSel = 3'(FLG_V);
    run(OP_FLAG_SET, 1);
    br(OP_BRANCH_ON_NO_OVERFLOW, 7'h05, 1'b0);
    br(OP_BRANCH_ON_IRQ_ENABLED, 7'h10, 1'b0);
    br(OP_BRANCH_ON_IRQ_DISABLED, 7'h3F, 1'b1);
    opFlagSel = 3'(FLG_I);
    run(OP_FLAG_SET, 1);
    br(OP_BRANCH_ON_IRQ_ENABLED, 7'h40, 1'b1);
    br(OP_BRANCH_ON_IRQ_DISABLED, 7'h01, 1'b0);
    opFlagSel = 3'(FLG_C);
    for (int i = 0; i < 8; i++) begin
      c = i[0];
      opRegData = c ? 8'h81 : 8'h80;
      run(c ? OP_FLAG_SET : OP_FLAG_CLEAR, 1);
      fl = statusFlags;
      case (i[2:1])
        2'h0: {fl[0], r} = {opRegData, 1'b0};
        2'h1: {r, fl[0]} = {1'b0, opRegData};
        2'h2: {fl[0], r} = {opRegData, c};
        default: {r, fl[0]} = {c, opRegData};
      endcase
      fl[3:1] = {r[7] ^ fl[0], r[7], r == 8'h00};
      k = bbx_op_t'(int'(OP_SHIFT_LEFT_LOGICAL) + i / 2);
      run(k, 1);
      chk("shift", 16'(regWrData), 16'(r));
      chk("sflags", 16'(statusFlags), 16'(fl));
    end
    opRegData = 8'h10;
    opBitSel = 3'h4;
    fl = statusFlags | 8'h40;
    run(OP_BIT_TO_TFLAG, 1);
    chk("tflag", 16'(statusFlags), 16'(fl));
    opRegData = 8'h00;
    opBitSel = 3'h3;
    opRegIdx = 5'h09;
    run(OP_TFLAG_TO_BIT, 1);
    chk("tbit", {3'h0, regWrIdx, regWrData}, 16'h0908);
    chk("tkeep", 16'(statusFlags), 16'(fl));
    opIoAddr = 6'h15;
    for (int j = 0; j < 2; j++) begin
      opBitSel = j ? 3'h7 : 3'h0;
      run(j ? OP_IO_BIT_CLEAR : OP_IO_BIT_SET, 2);
      r = 8'hD6;
      r[opBitSel] = (j == 0);
      chk("io", {2'h0, ioAddr, ioWrData}, {2'h0, opIoAddr, r});
      chk("ioflags", 16'(statusFlags), 16'(fl));
    end
    setPtr(PTR_X, 16'h01FF);
    memLoad(OP_INDIRECT_LOAD_INC, PTR_X, 16'h01FF, 16'h0200);
    memLoad(OP_INDIRECT_LOAD, PTR_X, 16'h0200, 16'h0200);
    setPtr(PTR_Y, 16'h0100);
    memLoad(OP_INDIRECT_LOAD_DEC, PTR_Y, 16'h00FF, 16'h00FF);
    setPtr(PTR_Z, 16'h0300);
    opDisp = 6'h3F;
    memLoad(OP_DISPLACED_LOAD, PTR_Z, 16'h033F, 16'h0300);
    opPtrSel = PTR_Y;
    memStore(OP_INDIRECT_STORE_INC, 16'h00FF, 16'h0100);
    memStore(OP_INDIRECT_STORE_DEC, 16'h00FF, 16'h00FF);
    memStore(OP_INDIRECT_STORE, 16'h00FF, 16'h00FF);
    memStore(OP_DISPLACED_STORE, 16'h013E, 16'h00FF);
    opDirectAddr = 16'h0460;
    memStore(OP_DIRECT_STORE, 16'h0460, 16'h00FF);
    setPtr(PTR_Z, 16'h0103);
    opRegIdx = 5'h05;
    run(OP_PROGRAM_MEMORY_LOAD_INC, 3);
    chk("pm", {3'h0, regWrIdx, regWrData}, 16'h0581);
    chk("pmptr", ptrZ, 16'h0104);
    run(OP_PROGRAM_MEMORY_LOAD_R0, 3);
    chk("pm0", {3'h0, regWrIdx, regWrData}, 16'h007D);
    run(OP_PROGRAM_MEMORY_LOAD, 3);
    chk("pmrd", {3'h0, regWrIdx, regWrData}, 16'h057D);
    wrap_up();
  end
endmodule : bbx_exec_bench
`default_nettype wire
